/* src/idr_defines.svh */
// constants for the identify data responder: command codes, word layout, timing
// assumes inclusion by bare name from the responder, checker and testbench files
`ifndef IDR_DEFINES_SVH
`define IDR_DEFINES_SVH
`define IDR_CMD_IDENTIFY 8'hEC
`define IDR_BLOCK_WORDS 9'h100
`define IDR_LAST_WORD 8'hFF
`define IDR_W_CONFIG 8'h00
`define IDR_W_SERIAL_LO 8'h0A
`define IDR_W_SERIAL_HI 8'h13
`define IDR_W_FW_LO 8'h17
`define IDR_W_FW_HI 8'h1A
`define IDR_W_MODEL_LO 8'h1B
`define IDR_W_MODEL_HI 8'h2E
`define IDR_W_MULTI 8'h2F
`define IDR_W_CAP1 8'h31
`define IDR_W_CAP2 8'h32
`define IDR_W_VALID 8'h35
`define IDR_W_SECT_LO 8'h3C
`define IDR_W_SECT_HI 8'h3D
`define IDR_B_ATA 15
`define IDR_B_REMOVABLE 7
`define IDR_B_INCOMPLETE 2
`define IDR_MULTI_HI 8'h80
`define IDR_B_STBY_STD 13
`define IDR_B_IORDY 11
`define IDR_B_IORDY_DIS 10
`define IDR_B_LBA 9
`define IDR_B_DMA 8
`define IDR_B_CAP2_ZERO 15
`define IDR_B_CAP2_ONE 14
`define IDR_B_STBY_MIN 0
`define IDR_B_W88_VALID 2
`define IDR_B_W64_VALID 1
`define IDR_ERR_ABRT 8'h04
`define IDR_SIG_COUNT 8'h01
`define IDR_SIG_LBA_LOW 8'h01
`define IDR_SIG_LBA_MID 8'h14
`define IDR_SIG_LBA_HIGH 8'hEB
`define IDR_PREP_NS 400
`define IDR_CLK_NS 40
`define IDR_PREP_CYC ((`IDR_PREP_NS + `IDR_CLK_NS - 1) / `IDR_CLK_NS)
`endif

/* src/idr_pkg.sv */
// types for the identify data responder
// assumes idr_defines.svh on the include path
package idr_pkg;
    typedef enum logic [2:0] {
        IDR_IDLE = 3'b000,
        IDR_PREP = 3'b001,
        IDR_XFER = 3'b010,
        IDR_DRAIN = 3'b011,
        IDR_ABORT = 3'b100
    } idr_state_e;
    typedef struct packed {
        logic bsy;
        logic drdy;
        logic df;
        logic drq;
        logic err;
    } idr_status_s;
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] lba_low;
        logic [7:0] lba_mid;
        logic [7:0] lba_high;
    } idr_sig_s;
    typedef struct packed {
        logic removable;
        logic incomplete;
        logic stby_std;
        logic iordy;
        logic iordy_dis;
        logic lba;
        logic dma;
        logic w88_valid;
        logic w64_valid;
        logic packet_dev;
        logic [7:0] max_multi;
        logic [31:0] total_sectors;
    } idr_cfg_s;
endpackage

/* src/idr_buf2.sv */
// two-entry word buffer with valid and ready on both sides
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/1ps
module idr_buf2 (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [15:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [15:0] out_data
);
    logic [15:0] mem_reg [0:1];
    logic [15:0] mem_next [0:1];
    logic rd_reg, rd_next, wr_reg, wr_next;
    logic [1:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_next[0] = mem_reg[0];
        mem_next[1] = mem_reg[1];
        rd_next = rd_reg;
        wr_next = wr_reg;
        cnt_next = cnt_reg;
        if (flush) begin
            rd_next = 1'b0;
            wr_next = 1'b0;
            cnt_next = 2'h0;
        end else begin
            if (push) begin
                mem_next[wr_reg] = in_data;
                wr_next = ~wr_reg;
            end
            if (pop) begin
                rd_next = ~rd_reg;
            end
            cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge ref_clk) begin
        mem_reg[0] <= mem_next[0];
        mem_reg[1] <= mem_next[1];
        if (!rstn) begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule // idr_buf2

/* src/idr_responder.sv */
// identify command responder: builds the 256-word parameter block and returns it by pio data-in
// assumes a task-file front end on ref_clk that presents command writes and data-register reads as pulses
// Notes on behaviour
// RULE1: on identify, set busy, prepare block, then raise drq, drop busy, interrupt if enabled.
// RULE2: host reads the data register once per word after drq.
// RULE3: reserved bits and words of the block are zero.
// RULE4: sixteen-bit values go msb on dd15, lsb on dd0.
// RULE5: thirty-two-bit values go low word first, then high word.
// RULE6: word 0: bit 15 zero, bit 7 removable, bit 2 incomplete.
// RULE7: words 10 to 19 hold a 20-character serial string.
// RULE8: words 23 to 26 hold an 8-character firmware string.
// RULE9: words 27 to 46 hold a 40-character model string.
// RULE10: word 47 high byte 80h, low byte max sectors per interrupt, never 00h.
// RULE11: word 49 bit 13 flags standard standby timer values.
// RULE12: word 49 bits 11, 10, 9, 8: iordy, iordy disable, lba, dma.
// RULE13: word 50 bit 15 zero, bit 14 one, bit 0 one.
// RULE14: word 53 bit 2 validates word 88, bit 1 words 64 to 70.
// RULE15: host issues identify only while drdy reads one.
// RULE16: packet devices abort and load the packet signature instead.
// RULE17: on completion busy 0, drdy 1, fault 0, drq 0, err 0, dev selected.
`timescale 1ns/1ps
`include "idr_defines.svh"
module idr_responder (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic dev_sel,
    input wire logic nien,
    input wire logic data_rd,
    input wire idr_pkg::idr_cfg_s cfg,
    input wire logic [159:0] serial_str,
    input wire logic [63:0] fw_str,
    input wire logic [319:0] model_str,
    output idr_pkg::idr_status_s status,
    output logic dev_bit,
    output logic [7:0] error_reg,
    output idr_pkg::idr_sig_s sig,
    output logic [15:0] dd_out,
    output logic intrq
);
    import idr_pkg::*;

    // pick the two characters of a string word; first character in the upper byte
    function automatic logic [15:0] str_word(input logic [319:0] s, input logic [7:0] idx, input logic [7:0] n);
        logic [8:0] pos;
        pos = 9'(n - 8'h1 - idx) << 4;
        str_word = s[pos +: 16];
    endfunction

    // true when word index w falls inside a field of several words
    function automatic logic in_range(input logic [7:0] w, input logic [7:0] lo, input logic [7:0] hi);
        in_range = (w >= lo) && (w <= hi);
    endfunction

    function automatic logic [15:0] build_word(input logic [7:0] w, input idr_cfg_s c,
                                               input logic [159:0] sn, input logic [63:0] fw,
                                               input logic [319:0] mn);
        logic [15:0] v;
        v = 16'h0000; // RULE3
        if (w == `IDR_W_CONFIG) begin
            v[`IDR_B_ATA] = 1'b0; // RULE6
            v[`IDR_B_REMOVABLE] = c.removable; // RULE6
            v[`IDR_B_INCOMPLETE] = c.incomplete; // RULE6
        end else if (in_range(w, `IDR_W_SERIAL_LO, `IDR_W_SERIAL_HI)) begin
            v = str_word({160'h0, sn}, w - `IDR_W_SERIAL_LO, 8'h0A); // RULE7
        end else if (in_range(w, `IDR_W_FW_LO, `IDR_W_FW_HI)) begin
            v = str_word({256'h0, fw}, w - `IDR_W_FW_LO, 8'h04); // RULE8
        end else if (in_range(w, `IDR_W_MODEL_LO, `IDR_W_MODEL_HI)) begin
            v = str_word(mn, w - `IDR_W_MODEL_LO, 8'h14); // RULE9
        end else if (w == `IDR_W_MULTI) begin
            // 00h is reserved, so an unset limit reads as one sector
            v = {`IDR_MULTI_HI, (c.max_multi == 8'h00) ? 8'h01 : c.max_multi}; // RULE10
        end else if (w == `IDR_W_CAP1) begin
            v[`IDR_B_STBY_STD] = c.stby_std; // RULE11
            v[`IDR_B_IORDY] = c.iordy; // RULE12
            v[`IDR_B_IORDY_DIS] = c.iordy_dis; // RULE12
            v[`IDR_B_LBA] = c.lba; // RULE12
            v[`IDR_B_DMA] = c.dma; // RULE12
        end else if (w == `IDR_W_CAP2) begin
            v[`IDR_B_CAP2_ZERO] = 1'b0; // RULE13
            v[`IDR_B_CAP2_ONE] = 1'b1; // RULE13
            v[`IDR_B_STBY_MIN] = 1'b1; // RULE13
        end else if (w == `IDR_W_VALID) begin
            v[`IDR_B_W88_VALID] = c.w88_valid; // RULE14
            v[`IDR_B_W64_VALID] = c.w64_valid; // RULE14
        end else if (w == `IDR_W_SECT_LO) begin
            v = c.total_sectors[15:0]; // RULE5
        end else if (w == `IDR_W_SECT_HI) begin
            v = c.total_sectors[31:16]; // RULE5
        end
        build_word = v;
    endfunction

    // preparation delay stands in for fetching the block from media
    localparam logic [7:0] PREP_CYC = 8'(`IDR_PREP_CYC);

    idr_state_e state_reg, state_next;
    logic [7:0] gen_reg, gen_next;
    logic [8:0] left_reg, left_next;
    logic [7:0] prep_reg, prep_next;
    logic gen_done_reg, gen_done_next;
    idr_status_s status_reg, status_next;
    logic dev_reg, dev_next;
    logic [7:0] error_next, error_q;
    idr_sig_s sig_reg, sig_next;
    logic [15:0] dd_reg, dd_next;
    logic intrq_reg, intrq_next;
    idr_cfg_s cfg_reg, cfg_next;
    logic [159:0] sn_reg, sn_next;
    logic [63:0] fw_reg, fw_next;
    logic [319:0] mn_reg, mn_next;

    logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready, buf_flush;
    logic [15:0] buf_out_data, word_now;
    logic cmd_take;

    // word for the current index, built from the command snapshot
    assign word_now = build_word(gen_reg, cfg_reg, sn_reg, fw_reg, mn_reg);
    assign buf_in_valid = (state_reg == IDR_PREP || state_reg == IDR_XFER) && !gen_done_reg;
    // idle and abort empty the buffer so a new command never sees stale words
    assign buf_flush = (state_reg == IDR_IDLE) || (state_reg == IDR_ABORT);
    // identify is taken only in idle; commands while busy are ignored
    assign cmd_take = (state_reg == IDR_IDLE) && cmd_wr && (cmd_code == `IDR_CMD_IDENTIFY);

    idr_buf2 u_buf (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .flush(buf_flush),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(word_now),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // a data-register read consumes the word shown; the next one is loaded behind it
    assign buf_out_ready = (state_reg == IDR_XFER) && status_reg.drq && data_rd; // RULE2

    always_comb begin
        state_next = state_reg;
        left_next = left_reg;
        prep_next = prep_reg;
        status_next = status_reg;
        dev_next = dev_reg;
        error_next = error_q;
        sig_next = sig_reg;
        dd_next = dd_reg;
        intrq_next = intrq_reg;
        unique case (state_reg)
            IDR_IDLE: begin
                if (cmd_take) begin
                    status_next.bsy = 1'b1; // RULE1
                    status_next.drq = 1'b0;
                    status_next.err = 1'b0;
                    intrq_next = 1'b0;
                    error_next = 8'h00;
                    dev_next = dev_sel; // RULE17
                    left_next = `IDR_BLOCK_WORDS;
                    prep_next = PREP_CYC;
                    state_next = cfg.packet_dev ? IDR_ABORT : IDR_PREP; // RULE16
                end
            end
            // hold busy for the delay, then show word 0
            IDR_PREP: begin
                if (prep_reg != 8'h00) begin
                    prep_next = prep_reg - 8'h01;
                end else if (buf_out_valid) begin
                    dd_next = buf_out_data; // RULE4
                    status_next.drq = 1'b1; // RULE1
                    status_next.bsy = 1'b0; // RULE1
                    intrq_next = !nien; // RULE1
                    state_next = IDR_XFER;
                end
            end
            // each read but the last drops drq while the next word is loaded
            IDR_XFER: begin
                if (buf_out_ready) begin
                    intrq_next = 1'b0;
                    left_next = left_reg - 9'h001;
                    if (left_reg == 9'h001) begin
                        state_next = IDR_DRAIN;
                    end else begin
                        status_next.drq = 1'b0;
                        status_next.bsy = 1'b1;
                    end
                end else if (!status_reg.drq && buf_out_valid) begin
                    dd_next = buf_out_data; // RULE4
                    status_next.drq = 1'b1;
                    status_next.bsy = 1'b0;
                end
            end
            // completion status one cycle after the last read
            IDR_DRAIN: begin
                status_next.bsy = 1'b0; // RULE17
                status_next.drdy = 1'b1; // RULE17
                status_next.df = 1'b0; // RULE17
                status_next.drq = 1'b0; // RULE17
                status_next.err = 1'b0; // RULE17
                state_next = IDR_IDLE;
            end
            // packet devices refuse the block and post the signature
            IDR_ABORT: begin
                status_next.bsy = 1'b0;
                status_next.drdy = 1'b1;
                status_next.drq = 1'b0;
                status_next.err = 1'b1; // RULE16
                error_next = `IDR_ERR_ABRT; // RULE16
                sig_next = '{`IDR_SIG_COUNT, `IDR_SIG_LBA_LOW, `IDR_SIG_LBA_MID, `IDR_SIG_LBA_HIGH}; // RULE16
                intrq_next = !nien;
                state_next = IDR_IDLE;
            end
            default: begin
                state_next = IDR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg <= IDR_IDLE;
            left_reg <= 9'h000;
            prep_reg <= 8'h00;
            status_reg <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            dev_reg <= 1'b0;
            error_q <= 8'h00;
            sig_reg <= '0;
            dd_reg <= 16'h0000;
            intrq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            left_reg <= left_next;
            prep_reg <= prep_next;
            status_reg <= status_next;
            dev_reg <= dev_next;
            error_q <= error_next;
            sig_reg <= sig_next;
            dd_reg <= dd_next;
            intrq_reg <= intrq_next;
        end
    end

    // word generator: walks the block index while the buffer has room
    always_comb begin
        gen_next = gen_reg;
        gen_done_next = gen_done_reg;
        if (cmd_take) begin
            gen_next = 8'h00;
            gen_done_next = 1'b0;
        end else if (buf_in_valid && buf_in_ready) begin
            gen_next = gen_reg + 8'h01;
            // stop after word 255 so no extra word queues behind the block
            gen_done_next = (gen_reg == `IDR_LAST_WORD);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            gen_reg <= 8'h00;
            gen_done_reg <= 1'b1;
        end else begin
            gen_reg <= gen_next;
            gen_done_reg <= gen_done_next;
        end
    end

    // command snapshot: the block stays consistent if the inputs move mid-transfer
    always_comb begin
        cfg_next = cfg_reg;
        sn_next = sn_reg;
        fw_next = fw_reg;
        mn_next = mn_reg;
        if (cmd_take) begin
            cfg_next = cfg;
            sn_next = serial_str;
            fw_next = fw_str;
            mn_next = model_str;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cfg_reg <= '0;
            sn_reg <= '0;
            fw_reg <= '0;
            mn_reg <= '0;
        end else begin
            cfg_reg <= cfg_next;
            sn_reg <= sn_next;
            fw_reg <= fw_next;
            mn_reg <= mn_next;
        end
    end

    assign status = status_reg;
    assign dev_bit = dev_reg;
    assign error_reg = error_q;
    assign sig = sig_reg;
    assign dd_out = dd_reg;
    assign intrq = intrq_reg;
endmodule // idr_responder

/* tb/idr_responder_checker.sv */
// assertions on the identify responder ports
// assumes cfg and nien stay put while a command runs
`timescale 1ns/1ps
`include "idr_defines.svh"
module idr_responder_checker
import idr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic dev_sel,
    input wire logic nien,
    input wire logic data_rd,
    input wire idr_pkg::idr_cfg_s cfg,
    input wire logic [159:0] serial_str,
    input wire logic [63:0] fw_str,
    input wire logic [319:0] model_str,
    input wire idr_pkg::idr_status_s status,
    input wire logic dev_bit,
    input wire logic [7:0] error_reg,
    input wire idr_pkg::idr_sig_s sig,
    input wire logic [15:0] dd_out,
    input wire logic intrq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [8:0] idx_reg;
    logic [8:0] idx_next;
    logic id_cmd;
    assign id_cmd = cmd_wr && cmd_code == `IDR_CMD_IDENTIFY && !status.bsy && !status.drq;
    // word index of the block, counted from accepted reads
    always_comb begin
        idx_next = idx_reg;
        if (!rstn || id_cmd) idx_next = 9'h000;
        else if (data_rd && status.drq) idx_next = idx_reg + 9'h001;
    end
    always_ff @(posedge ref_clk) begin
        idx_reg <= idx_next;
    end
    sequence s_prep;
        status.bsy ##[1:20] (status.drq && !status.bsy);
    endsequence
    sequence s_abort;
        status.err && !status.drq && error_reg == `IDR_ERR_ABRT
            && sig == {`IDR_SIG_COUNT, `IDR_SIG_LBA_LOW, `IDR_SIG_LBA_MID, `IDR_SIG_LBA_HIGH};
    endsequence
    chk_cmd_busy: assert property (id_cmd && !cfg.packet_dev |=> s_prep)
        else $error("identify did not go busy then drq");
    chk_irq_mask: assert property (nien |-> !$rose(intrq))
        else $error("interrupt raised while disabled");
    chk_irq_cause: assert property ($rose(intrq) |-> status.drq || status.err)
        else $error("interrupt without drq or error");
    chk_read_clear: assert property (data_rd && status.drq |=> !intrq)
        else $error("interrupt still high after a read");
    chk_cfg_word: assert property (status.drq && idx_reg == 9'h000
        |-> dd_out == {8'h00, cfg.removable, 4'h0, cfg.incomplete, 2'b00})
        else $error("word 0 wrong");
    chk_multi_word: assert property (status.drq && idx_reg == 9'h02F
        |-> dd_out == {8'h80, (cfg.max_multi == 8'h00) ? 8'h01 : cfg.max_multi})
        else $error("word 47 wrong");
    chk_cap_word: assert property (status.drq && idx_reg == 9'h031 |-> dd_out ==
        {2'b00, cfg.stby_std, 1'b0, cfg.iordy, cfg.iordy_dis, cfg.lba, cfg.dma, 8'h00})
        else $error("word 49 wrong");
    chk_cap2_word: assert property (status.drq && idx_reg == 9'h032 |-> dd_out == 16'h4001)
        else $error("word 50 wrong");
    chk_valid_word: assert property (status.drq && idx_reg == 9'h035
        |-> dd_out == {13'h0000, cfg.w88_valid, cfg.w64_valid, 1'b0})
        else $error("word 53 wrong");
    chk_sect_pair: assert property (status.drq && (idx_reg == 9'h03C || idx_reg == 9'h03D) |-> dd_out ==
        (idx_reg[0] ? cfg.total_sectors[31:16] : cfg.total_sectors[15:0]))
        else $error("sector count halves wrong");
    chk_reserved_zero: assert property (status.drq
        && (idx_reg == 9'h030 || (idx_reg >= 9'h03E && idx_reg <= 9'h0FF)) |-> dd_out == 16'h0000)
        else $error("reserved word not zero");
    chk_packet_abort: assert property (id_cmd && cfg.packet_dev |-> ##[1:4] s_abort)
        else $error("packet device did not abort");
    chk_done_status: assert property ($fell(status.drq) && idx_reg == 9'h100
        |-> !status.bsy && status.drdy && !status.df && !status.err)
        else $error("completion status wrong");
endmodule // idr_responder_checker

bind idr_responder idr_responder_checker i_chk (.ref_clk, .rstn, .cmd_wr, .cmd_code, .dev_sel, .nien,
    .data_rd, .cfg, .serial_str, .fw_str, .model_str, .status, .dev_bit, .error_reg, .sig, .dd_out, .intrq);

/* tb/idr_host_model.sv */
// host adapter model: issues commands and reads the data register
// assumes the responder status and data word on ref_clk
`timescale 1ns/1ps
module idr_host_model
import idr_pkg::*;
(
    input wire logic ref_clk,
    input wire idr_pkg::idr_status_s status,
    input wire logic [15:0] dd_out,
    output logic cmd_wr,
    output logic [7:0] cmd_code,
    output logic data_rd
);
    logic [15:0] blk [256];
    initial begin
        cmd_wr = 1'b0;
        cmd_code = 8'h00;
        data_rd = 1'b0;
    end
    task issue(input logic [7:0] code);
        int w;
        w = 0;
        do begin @(posedge ref_clk); w++; end
        while ((status.drdy !== 1'b1 || status.bsy !== 1'b0) && w < 40);
        cmd_wr <= 1'b1;
        cmd_code <= code;
        @(posedge ref_clk);
        cmd_wr <= 1'b0;
    endtask
    // one word per read, only while drq stands
    task read_block(input int gap, output int n);
        int w;
        n = 0;
        for (int i = 0; i < 256; i++) begin
            repeat (gap) @(posedge ref_clk);
            w = 0;
            do begin @(posedge ref_clk); w++; end while (status.drq !== 1'b1 && w < 40);
            if (status.drq !== 1'b1) return;
            blk[i] = dd_out;
            data_rd <= 1'b1;
            @(posedge ref_clk);
            data_rd <= 1'b0;
            n++;
        end
    endtask
endmodule // idr_host_model

/* tb/idr_responder_tb.sv */
// testbench for the identify responder with a host model
// assumes the checker is bound to the responder
`timescale 1ns/1ps
`include "idr_defines.svh"
module idr_responder_tb;
    import idr_pkg::*;
    logic ref_clk, rstn, dev_sel, nien, cmd_wr, data_rd, dev_bit, intrq;
    logic [7:0] cmd_code, error_reg;
    logic [159:0] serial_str;
    logic [63:0] fw_str;
    logic [319:0] model_str;
    logic [15:0] dd_out;
    idr_cfg_s cfg;
    idr_status_s status;
    idr_sig_s sig;
    int errors, n_checks;
    int irq_cnt;
    idr_responder i_dut (.ref_clk, .rstn, .cmd_wr, .cmd_code, .dev_sel, .nien, .data_rd, .cfg, .serial_str,
        .fw_str, .model_str, .status, .dev_bit, .error_reg, .sig, .dd_out, .intrq);
    idr_host_model i_host (.ref_clk, .status, .dd_out, .cmd_wr, .cmd_code, .data_rd);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (intrq === 1'b1) irq_cnt <= irq_cnt + 1;
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    function automatic logic [15:0] exp_word(input int i);
        if (i == 0) return {8'h00, cfg.removable, 4'h0, cfg.incomplete, 2'b00};
        if (i >= 10 && i <= 19) return serial_str[159 - 16 * (i - 10) -: 16];
        if (i >= 23 && i <= 26) return fw_str[63 - 16 * (i - 23) -: 16];
        if (i >= 27 && i <= 46) return model_str[319 - 16 * (i - 27) -: 16];
        if (i == 47) return {8'h80, (cfg.max_multi == 8'h00) ? 8'h01 : cfg.max_multi};
        if (i == 49) return {2'b00, cfg.stby_std, 1'b0, cfg.iordy, cfg.iordy_dis, cfg.lba, cfg.dma, 8'h00};
        if (i == 50) return 16'h4001;
        if (i == 53) return {13'h0000, cfg.w88_valid, cfg.w64_valid, 1'b0};
        if (i == 60) return cfg.total_sectors[15:0];
        if (i == 61) return cfg.total_sectors[31:16];
        return 16'h0000;
    endfunction
    task t_identify(input logic nien_v, input int gap);
        int n, irq0;
        nien <= nien_v;
        irq0 = irq_cnt;
        i_host.issue(`IDR_CMD_IDENTIFY);
        @(posedge ref_clk);
        check(status.bsy, 1'b1);
        i_host.read_block(gap, n);
        check(n, 256);
        check(irq_cnt != irq0, !nien_v);
        for (int i = 0; i < 256; i++) begin
            check(i_host.blk[i], exp_word(i));
        end
        repeat (3) @(posedge ref_clk);
        check({status, dev_bit}, {5'b01000, dev_sel});
        $display("identify test done, nien=%0d gap=%0d", nien_v, gap);
    endtask
    task t_packet;
        int irq0;
        cfg.packet_dev <= 1'b1;
        nien <= 1'b0;
        irq0 = irq_cnt;
        i_host.issue(`IDR_CMD_IDENTIFY);
        repeat (4) @(posedge ref_clk);
        check({status.err, status.drq, error_reg}, {2'b10, 8'h04});
        check(sig, {`IDR_SIG_COUNT, `IDR_SIG_LBA_LOW, `IDR_SIG_LBA_MID, `IDR_SIG_LBA_HIGH});
        check(irq_cnt != irq0, 1'b1);
        // mid-run reset returns the responder to idle
        rstn <= 1'b0;
        cfg.packet_dev <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        $display("packet abort test done");
    endtask
    task t_refused;
        i_host.issue(8'hE0);
        repeat (3) @(posedge ref_clk);
        check({status.bsy, status.drq}, 2'b00);
        $display("foreign command test done");
    endtask
    initial begin
        rstn = 1'b0;
        nien = 1'b0;
        dev_sel = 1'b1;
        errors = 0;
        n_checks = 0;
        cfg = {10'b1011010100, 8'h10, 32'h12345678};
        serial_str = "SN-0042-TEST-UNIT-01";
        fw_str = "REV1.0AB";
        model_str = "DISK-MODEL-0123456789-ABCDEFGHIJKLMNOPQR";
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        t_refused;
        t_identify(1'b0, 0);
        cfg <= {10'b0100101010, 8'h00, 32'hA5C30FF1};
        dev_sel <= 1'b0;
        t_identify(1'b1, 3);
        t_packet;
        t_identify(1'b0, 1);
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        wrap_up;
    end
endmodule // idr_responder_tb
